// File: rtl/pa_timer_port_consts.vh
// constants for the pulse accumulator and timer port block
`ifndef PA_TIMER_PORT_CONSTS_VH
`define PA_TIMER_PORT_CONSTS_VH

// ---------------------------------------------------------------
// register indices (byte address = index * 4)
// ---------------------------------------------------------------
`define IDX_CHANNEL6_VALUE        8'h9C
`define IDX_CHANNEL7_VALUE        8'h9E
`define IDX_ACCUMULATOR_CONTROL   8'hA0
`define IDX_ACCUMULATOR_FLAGS     8'hA1
`define IDX_ACCUMULATOR_COUNT     8'hA2
`define IDX_TIMER_TEST_BYPASS     8'hAD
`define IDX_TIMER_PORT_PINS       8'hAE
`define IDX_TIMER_PORT_DIRECTION  8'hAF
`define IDX_TIMER_CONTROL         8'hB0
`define IDX_CHANNEL_CONTROL       8'hB1
`define IDX_TIMER_COUNT           8'hB2

// ---------------------------------------------------------------
// accumulator_control fields
// ---------------------------------------------------------------
`define ACC_ENABLE_POS       6
`define ACC_MODE_POS         5
`define ACC_EDGE_POS         4
`define CLK_SEL_HI_POS       3
`define CLK_SEL_LO_POS       2
`define OVF_IRQ_EN_POS       1
`define IN_IRQ_EN_POS        0
`define ACC_CONTROL_RESET    8'h00

// accumulator_flags fields
`define OVF_FLAG_POS         1
`define IN_FLAG_POS          0

// timer_test_bypass fields
`define CNT_SPLIT_POS        1
`define ACC_SPLIT_POS        0

// timer_control fields
`define TMR_ENABLE_POS       7
`define WAIT_STOP_POS        6
`define DEBUG_STOP_POS       5
`define FAST_CLEAR_POS       4
`define PRESCALE_HI          2
`define TIMER_CONTROL_RESET  8'h00

// channel_control fields: function select, edge select, output action
`define FSEL6_POS            0
`define FSEL7_POS            1
`define EDGE6_LO             2
`define EDGE7_LO             4
`define ACT6_LO              8
`define ACT7_LO              10
`define CHANNEL_CONTROL_RESET 12'h000

`define CHANNEL_VALUE_RESET  16'h0000
`define ACC_COUNT_RESET      16'h0000

// ---------------------------------------------------------------
// timing counts in module clocks
// ---------------------------------------------------------------
`define GATE_DIVIDE          64
`define GATE_TICK_LAST       6'h3F
`define PRESCALE_MAX_LOG2    5

`endif

// File: rtl/pa_timer_port.v
// pulse accumulator, channels 6/7, timer counter clocking and timer port pins
// Functional notes
// R01: channel value captures counter on qualified edge, or serves as compare match.
// R02: channel values readable always, writable only in compare, reset to zero.
// R03: accumulator enable turns accumulator on/off, independent of timer enable.
// R04: mode bit zero counts events, one accumulates gated time.
// R05: event mode counts falling edges with edge bit zero, rising with one.
// R06: gated mode gates divide-by-64 tick by pin level; trailing edge sets flag.
// R07: divide-by-64 tick comes from prescaler, absent while timer disabled.
// R08: clock select picks prescaler, accumulator clock, divided by 256 or 65536.
// R09: accumulator disabled forces prescaler clock onto timer counter.
// R10: clock select change takes effect immediately.
// R11: interrupt request while a flag is set and its enable is one.
// R12: overflow flag sets on wrap FFFF to 0000, cleared by writing bit 1.
// R13: input flag sets on counted or trailing edge, cleared by writing bit 0.
// R14: fast flag clear makes any count access clear both accumulator flags.
// R15: software accesses the accumulator count as one whole word.
// R16: test bypass writable in special mode only; splits counters into halves.
// R17: port read returns pin level for inputs, latched data for outputs; compare-driven pins read back the compare output instead.
// R18: port writes never change a pin driven by a compare output.
// R19: outside signals hold each level longer than two module clocks.
// R20: direction one is output; enabled compare forces output; capture does not.
// R21: halts in stop; debug and wait halt only with their stop bits.
// R22: accumulator disabled stops counting and flags, registers stay accessible.
// R23: accumulator input passes a two-stage synchronizer before any use.
`timescale 1ns/10ps
`include "pa_timer_port_consts.vh"

module pa_timer_port #(
    parameter ADDR_WIDTH = 12
) (
    input  wire                  clk,
    input  wire                  srst,
    input  wire                  psel,
    input  wire                  penable,
    input  wire                  pwrite,
    input  wire [ADDR_WIDTH-1:0] paddr,
    input  wire [31:0]           pwdata,
    output reg  [31:0]           prdata,
    output wire                  pready,
    output wire                  pslverr,
    input  wire                  stopMode,
    input  wire                  waitMode,
    input  wire                  debugMode,
    input  wire                  specialMode_n,
    input  wire [7:0]            portIn,
    output wire [7:0]            portOut,
    output wire [7:0]            portOe,
    output wire                  overflowIrq,
    output wire                  inputIrq,
    output wire [15:0]           timerCount
);

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    reg  [15:0] channel6Value;
    reg  [15:0] channel7Value;
    reg  [7:0]  accControl;
    reg         overflowFlag;
    reg         inputFlag;
    reg  [15:0] accCount;
    reg         counterSplit;
    reg         accSplit;
    reg  [7:0]  portLatch;
    reg  [7:0]  portDirection;
    reg  [7:0]  timerControl;
    reg  [11:0] channelControl;
    reg  [15:0] counter;
    reg  [5:0]  prescale;
    reg  [1:0]  compareOut;
    reg  [1:0]  sync1;
    reg  [1:0]  sync2;
    reg  [1:0]  syncPrev;

    // ---------------------------------------------------------------
    // apb decode
    // ---------------------------------------------------------------
    wire [7:0] regIndex  = paddr[9:2];
    wire       aligned   = (paddr[1:0] == 2'b00) && (paddr[ADDR_WIDTH-1:10] == {(ADDR_WIDTH-10){1'b0}});
    reg        mapped;
    wire       access    = psel && penable;
    wire       wrDone    = access && pwrite && mapped;
    wire       setup     = psel && !penable;

    assign pready  = 1'b1;
    assign pslverr = access && !mapped;

    always @* begin
        case (regIndex)
            `IDX_CHANNEL6_VALUE, `IDX_CHANNEL7_VALUE, `IDX_ACCUMULATOR_CONTROL,
            `IDX_ACCUMULATOR_FLAGS, `IDX_ACCUMULATOR_COUNT, `IDX_TIMER_TEST_BYPASS,
            `IDX_TIMER_PORT_PINS, `IDX_TIMER_PORT_DIRECTION, `IDX_TIMER_CONTROL,
            `IDX_CHANNEL_CONTROL, `IDX_TIMER_COUNT: mapped = aligned;
            default: mapped = 1'b0;
        endcase
    end

    wire wrChan6   = wrDone && regIndex == `IDX_CHANNEL6_VALUE;
    wire wrChan7   = wrDone && regIndex == `IDX_CHANNEL7_VALUE;
    wire wrCtrl    = wrDone && regIndex == `IDX_ACCUMULATOR_CONTROL;
    wire wrFlags   = wrDone && regIndex == `IDX_ACCUMULATOR_FLAGS;
    wire wrCount   = wrDone && regIndex == `IDX_ACCUMULATOR_COUNT;
    wire wrTest    = wrDone && regIndex == `IDX_TIMER_TEST_BYPASS;
    wire wrPort    = wrDone && regIndex == `IDX_TIMER_PORT_PINS;
    wire wrDir     = wrDone && regIndex == `IDX_TIMER_PORT_DIRECTION;
    wire wrTimer   = wrDone && regIndex == `IDX_TIMER_CONTROL;
    wire wrChanCtl = wrDone && regIndex == `IDX_CHANNEL_CONTROL;
    wire countHit  = access && mapped && regIndex == `IDX_ACCUMULATOR_COUNT;

    // ---------------------------------------------------------------
    // operating mode qualifiers
    // ---------------------------------------------------------------
    wire freeze    = stopMode                                                 // R21
                     || (debugMode && timerControl[`DEBUG_STOP_POS])
                     || (waitMode && timerControl[`WAIT_STOP_POS]);
    wire timerRun  = timerControl[`TMR_ENABLE_POS] && !freeze;                // R21
    wire accRun    = accControl[`ACC_ENABLE_POS] && !freeze;                  // R03 R22
    wire gatedMode = accControl[`ACC_MODE_POS];
    wire edgeSel   = accControl[`ACC_EDGE_POS];
    wire [1:0] clkSel = {accControl[`CLK_SEL_HI_POS], accControl[`CLK_SEL_LO_POS]};
    wire fastClear = timerControl[`FAST_CLEAR_POS];

    // ---------------------------------------------------------------
    // input synchronizer for pins 6 and 7 (pin 7 feeds the accumulator)
    // ---------------------------------------------------------------
    always @(posedge clk) begin
        if (srst) begin
            sync1    <= 2'b00;
            sync2    <= 2'b00;
            syncPrev <= 2'b00;
        end else begin
            sync1    <= portIn[7:6]; // R23
            sync2    <= sync1; // R23
            syncPrev <= sync2;
        end
    end

    wire [1:0] rise = sync2 & ~syncPrev;
    wire [1:0] fall = ~sync2 & syncPrev;

    // ---------------------------------------------------------------
    // prescaler and divide-by-64 tick
    // ---------------------------------------------------------------
    wire [2:0] prSel    = timerControl[`PRESCALE_HI:0];
    wire [2:0] prLog2   = (prSel > 3'd5) ? 3'd5 : prSel;
    wire [4:0] prMask   = (5'h01 << prLog2) - 5'h01;
    // one counter feeds prescaler and gating tick,
    // so the tick stops with the timer enable
    wire       preTick  = timerRun && ((prescale[4:0] & prMask) == prMask);
    wire       tick64   = timerRun && (prescale == `GATE_TICK_LAST); // R07

    always @(posedge clk) begin
        if (srst)
            prescale <= 6'h00;
        else if (timerRun)
            prescale <= prescale + 6'h01;
    end

    // ---------------------------------------------------------------
    // accumulator clock, count and flags
    // ---------------------------------------------------------------
    wire eventEdge = edgeSel ? rise[1] : fall[1];                             // R05
    wire gateOpen  = edgeSel ? !sync2[1] : sync2[1];                          // R06
    wire trailing  = edgeSel ? rise[1] : fall[1];                             // R06
    wire accClk    = accRun && (gatedMode ? (gateOpen && tick64) : eventEdge); // R04 R06
    wire inputSet  = accRun && (gatedMode ? trailing : eventEdge);            // R13 R22

    wire        lowWrap    = accClk && accCount[7:0] == 8'hFF;
    wire        highWrap   = accClk && accCount[15:8] == 8'hFF;
    wire        accWrap    = accSplit ? highWrap : (lowWrap && highWrap);     // R12
    wire [15:0] accNext    = accSplit ?                                       // R16
                             {accCount[15:8] + 8'h01, accCount[7:0] + 8'h01} :
                             accCount + 16'h0001;

    always @(posedge clk) begin
        if (srst) begin
            accCount <= `ACC_COUNT_RESET;
        end else if (wrCount) begin
            accCount <= pwdata[15:0]; // R15
        end else if (accClk) begin
            accCount <= accNext;
        end
    end

    // set wins over every clear path; a count write suppresses the overflow set
    wire clearAll = countHit && fastClear;                                    // R14
    always @(posedge clk) begin
        if (srst) begin
            overflowFlag <= 1'b0;
            inputFlag    <= 1'b0;
        end else begin
            if (accWrap && !wrCount)
                overflowFlag <= 1'b1; // R12
            else if (clearAll || (wrFlags && pwdata[`OVF_FLAG_POS]))
                overflowFlag <= 1'b0; // R12
            if (inputSet)
                inputFlag <= 1'b1; // R13
            else if (clearAll || (wrFlags && pwdata[`IN_FLAG_POS]))
                inputFlag <= 1'b0; // R13
        end
    end

    assign overflowIrq = overflowFlag && accControl[`OVF_IRQ_EN_POS];         // R11
    assign inputIrq    = inputFlag && accControl[`IN_IRQ_EN_POS];             // R11

    // ---------------------------------------------------------------
    // timer counter clock selection
    // ---------------------------------------------------------------
    reg counterTick;
    always @* begin
        if (!accControl[`ACC_ENABLE_POS]) begin
            counterTick = preTick; // R09
        end else begin
            case (clkSel)                                                     // R08 R10
                2'b00:   counterTick = preTick;
                2'b01:   counterTick = accClk;
                2'b10:   counterTick = lowWrap;
                2'b11:   counterTick = accClk && (accCount == 16'hFFFF);
                default: counterTick = preTick;
            endcase
        end
    end

    // bypass drives both halves every module clock while the timer runs, prescaler out of the path
    wire        cntStep = counterSplit ? timerRun : (counterTick && timerRun); // R16 R21
    wire [15:0] cntNext = counterSplit ?
                          {counter[15:8] + 8'h01, counter[7:0] + 8'h01} :
                          counter + 16'h0001;

    always @(posedge clk) begin
        if (srst)
            counter <= 16'h0000;
        else if (cntStep)
            counter <= cntNext;
    end

    assign timerCount = counter;

    // ---------------------------------------------------------------
    // channels 6 and 7: capture or compare
    // ---------------------------------------------------------------
    wire [1:0] isCompare = {channelControl[`FSEL7_POS], channelControl[`FSEL6_POS]};
    wire [1:0] edge6     = channelControl[`EDGE6_LO+1:`EDGE6_LO];
    wire [1:0] edge7     = channelControl[`EDGE7_LO+1:`EDGE7_LO];
    wire [1:0] act6      = channelControl[`ACT6_LO+1:`ACT6_LO];
    wire [1:0] act7      = channelControl[`ACT7_LO+1:`ACT7_LO];
    wire [1:0] cmpEnable = {isCompare[1] && act7 != 2'b00, isCompare[0] && act6 != 2'b00};

    wire cap6 = timerRun && !isCompare[0] &&
                ((edge6[0] && rise[0]) || (edge6[1] && fall[0]));              // R01
    wire cap7 = timerRun && !isCompare[1] &&
                ((edge7[0] && rise[1]) || (edge7[1] && fall[1]));              // R01
    wire match6 = cntStep && isCompare[0] && cntNext == channel6Value;        // R01
    wire match7 = cntStep && isCompare[1] && cntNext == channel7Value;        // R01

    always @(posedge clk) begin
        if (srst) begin
            channel6Value <= `CHANNEL_VALUE_RESET; // R02
            channel7Value <= `CHANNEL_VALUE_RESET; // R02
        end else begin
            if (cap6)
                channel6Value <= counter; // R01
            else if (wrChan6 && isCompare[0])
                channel6Value <= pwdata[15:0]; // R02
            if (cap7)
                channel7Value <= counter; // R01
            else if (wrChan7 && isCompare[1])
                channel7Value <= pwdata[15:0]; // R02
        end
    end

    // output action: 01 toggle, 10 clear, 11 set
    function nextAction;
        input [1:0] act;
        input       cur;
        begin
            case (act)
                2'b01:   nextAction = !cur;
                2'b10:   nextAction = 1'b0;
                2'b11:   nextAction = 1'b1;
                default: nextAction = cur;
            endcase
        end
    endfunction

    always @(posedge clk) begin
        if (srst) begin
            compareOut <= 2'b00;
        end else begin
            if (match6)
                compareOut[0] <= nextAction(act6, compareOut[0]); // R01
            if (match7)
                compareOut[1] <= nextAction(act7, compareOut[1]); // R01
        end
    end

    // ---------------------------------------------------------------
    // port pins
    // ---------------------------------------------------------------
    wire [7:0] compareDrive = {cmpEnable, 6'h00};
    wire [7:0] driveValue   = {compareOut, 6'h00};
    assign portOe  = portDirection | compareDrive;                            // R20
    assign portOut = (portLatch & ~compareDrive) | (driveValue & compareDrive); // R18
    wire [7:0] portRead = (portIn & ~portOe) | (portOut & portOe);            // R17

    // ---------------------------------------------------------------
    // register writes
    // ---------------------------------------------------------------
    always @(posedge clk) begin
        if (srst) begin
            accControl     <= `ACC_CONTROL_RESET;
            counterSplit   <= 1'b0;
            accSplit       <= 1'b0;
            portLatch      <= 8'h00;
            portDirection  <= 8'h00;
            timerControl   <= `TIMER_CONTROL_RESET;
            channelControl <= `CHANNEL_CONTROL_RESET;
        end else begin
            if (wrCtrl)
                accControl <= {1'b0, pwdata[6:0]}; // R03 R10
            if (wrTest && !specialMode_n) begin
                counterSplit <= pwdata[`CNT_SPLIT_POS]; // R16
                accSplit     <= pwdata[`ACC_SPLIT_POS]; // R16
            end
            if (wrPort)
                portLatch <= pwdata[7:0]; // R18
            if (wrDir)
                portDirection <= pwdata[7:0]; // R20
            if (wrTimer)
                timerControl <= {pwdata[7:4], 1'b0, pwdata[2:0]};
            if (wrChanCtl)
                channelControl <= pwdata[11:0];
        end
    end

    // ---------------------------------------------------------------
    // read data, captured in the setup cycle so it is stable in access
    // ---------------------------------------------------------------
    reg [31:0] readMux;
    always @* begin
        readMux = 32'h00000000;
        case (regIndex)
            `IDX_CHANNEL6_VALUE:       readMux[15:0] = channel6Value;         // R02
            `IDX_CHANNEL7_VALUE:       readMux[15:0] = channel7Value;         // R02
            `IDX_ACCUMULATOR_CONTROL:  readMux[7:0]  = accControl;
            `IDX_ACCUMULATOR_FLAGS:    readMux[1:0]  = {overflowFlag, inputFlag};
            `IDX_ACCUMULATOR_COUNT:    readMux[15:0] = accCount;              // R15
            `IDX_TIMER_TEST_BYPASS:    readMux[1:0]  = {counterSplit, accSplit};
            `IDX_TIMER_PORT_PINS:      readMux[7:0]  = portRead;              // R17
            `IDX_TIMER_PORT_DIRECTION: readMux[7:0]  = portDirection;
            `IDX_TIMER_CONTROL:        readMux[7:0]  = timerControl;
            `IDX_CHANNEL_CONTROL:      readMux[11:0] = channelControl;
            `IDX_TIMER_COUNT:          readMux[15:0] = counter;
            default:                   readMux       = 32'h00000000;
        endcase
        if (!aligned)
            readMux = 32'h00000000;
    end

    always @(posedge clk) begin
        if (srst)
            prdata <= 32'h00000000;
        else if (setup && !pwrite)
            prdata <= readMux;
    end

endmodule

// File: dv/pa_timer_port_assertions.sv
// concurrent checks on the pulse accumulator timer port block
`timescale 1ns/10ps
`include "pa_timer_port_consts.vh"
module pa_timer_port_assertions #(
    parameter ADDR_WIDTH = 12
) (
    input wire logic                  clk,
    input wire logic                  srst,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0]           pwdata,
    input wire logic                  stopMode,
    input wire logic                  waitMode,
    input wire logic                  debugMode,
    input wire logic [7:0]            portIn,
    input wire logic [7:0]            portOe,
    input wire logic                  overflowIrq,
    input wire logic                  inputIrq,
    input wire logic [15:0]           timerCount
);
    // irq enables are invisible at the pins
    logic [7:0] ctl;
    wire        wrAcc = psel && penable && pwrite && paddr[1:0] == 2'h0 && paddr[ADDR_WIDTH-1:10] == '0;
    wire [7:0]  idx   = paddr[9:2];
    always @(posedge clk) begin
        if (srst)
            ctl <= 8'h00;
        else if (wrAcc && idx == `IDX_ACCUMULATOR_CONTROL)
            ctl <= pwdata[7:0];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    a_in_irq_gated: assert property (inputIrq |-> ctl[`IN_IRQ_EN_POS])
        else $error("input irq without enable");
    a_ovf_irq_gated: assert property (overflowIrq |-> ctl[`OVF_IRQ_EN_POS])
        else $error("overflow irq without enable");
    a_acc_off_quiet: assert property (!ctl[`ACC_ENABLE_POS] && ctl[`OVF_IRQ_EN_POS] && !overflowIrq
        && !(wrAcc && idx == `IDX_ACCUMULATOR_CONTROL) |=> !overflowIrq)
        else $error("overflow while accumulator off");
    a_in_flag_clear: assert property (wrAcc && idx == `IDX_ACCUMULATOR_FLAGS && pwdata[`IN_FLAG_POS]
        |=> !inputIrq)
        else $error("input flag not cleared");
    a_ovf_flag_clear: assert property (wrAcc && idx == `IDX_ACCUMULATOR_FLAGS && pwdata[`OVF_FLAG_POS]
        |=> !overflowIrq)
        else $error("overflow flag not cleared");
    a_dir_output: assert property (wrAcc && idx == `IDX_TIMER_PORT_DIRECTION
        |=> (portOe & $past(pwdata[7:0])) == $past(pwdata[7:0]))
        else $error("direction bit not driving pin");
    a_stop_freeze: assert property (stopMode |=> $stable(timerCount))
        else $error("counter moved in stop");
    a_event_flag: assert property ($fell(portIn[7]) && ctl[6:4] == 3'h4 && ctl[`IN_IRQ_EN_POS]
        && !stopMode && !waitMode && !debugMode |-> ##[1:4] inputIrq)
        else $error("falling edge not flagged");
endmodule
bind pa_timer_port pa_timer_port_assertions #(.ADDR_WIDTH(ADDR_WIDTH)) pa_timer_port_assertions_inst (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .stopMode(stopMode), .waitMode(waitMode), .debugMode(debugMode), .portIn(portIn),
    .portOe(portOe), .overflowIrq(overflowIrq), .inputIrq(inputIrq), .timerCount(timerCount));

// File: dv/port_pin_model.sv
// signal sources and loads on the timer port pins
`timescale 1ns/10ps
module port_pin_model (
    input  wire logic [7:0] srcLevel,
    input  wire logic [7:0] portOut,
    input  wire logic [7:0] portOe,
    output logic      [7:0] portIn
);
    // a driven pin reads back its own level, the others follow the outside sources
    assign portIn = (portOe & portOut) | (~portOe & srcLevel);
endmodule

// File: dv/pa_timer_port_tb.sv
// self-checking bench for the pulse accumulator timer port block
`timescale 1ns/10ps
`include "pa_timer_port_consts.vh"
module pa_timer_port_tb;
    localparam CTL = `IDX_ACCUMULATOR_CONTROL;
    localparam FLG = `IDX_ACCUMULATOR_FLAGS;
    localparam CNT = `IDX_ACCUMULATOR_COUNT;
    localparam TCR = `IDX_TIMER_CONTROL;
    localparam CH6 = `IDX_CHANNEL6_VALUE;
    localparam TST = `IDX_TIMER_TEST_BYPASS;
    logic        clk, srst, psel, penable, pwrite, pready, pslverr, err;
    logic        stopMode, waitMode, debugMode, specialMode_n, overflowIrq, inputIrq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  srcLevel, portIn, portOut, portOe;
    logic [15:0] timerCount, t1;
    int          errTotal, checksDone;

    pa_timer_port pa_timer_port_inst (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .stopMode(stopMode),
        .waitMode(waitMode), .debugMode(debugMode), .specialMode_n(specialMode_n), .portIn(portIn),
        .portOut(portOut), .portOe(portOe), .overflowIrq(overflowIrq), .inputIrq(inputIrq), .timerCount(timerCount));
    port_pin_model port_pin_model_inst (.srcLevel(srcLevel), .portOut(portOut), .portOe(portOe), .portIn(portIn));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            errTotal++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, i, 2'h0};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge clk);
    endtask

    task automatic rdchk(input logic [7:0] i, input logic [31:0] exp);
        apb(1'b0, i, 32'h0);
        chk(rd, exp);
    endtask

    task automatic pulses(input int n, input logic lvl, input int hold);
        repeat (n) begin
            @(posedge clk);
            srcLevel[7] <= lvl;
            repeat (hold) @(posedge clk);
            srcLevel[7] <= ~lvl;
            repeat (4) @(posedge clk);
        end
    endtask

    task automatic freeze(input logic frozen);
        repeat (2) @(negedge clk);
        t1 = timerCount;
        repeat (10) @(negedge clk);
        chk(timerCount === t1, frozen);
        @(posedge clk);
    endtask

    task automatic t_reset();
        logic [7:0] regs [6] = '{CH6, `IDX_CHANNEL7_VALUE, CTL, FLG, CNT, `IDX_TIMER_PORT_DIRECTION};
        foreach (regs[k]) rdchk(regs[k], 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk(err, 1'b1);
        apb(1'b1, CH6, 32'h1234);
        rdchk(CH6, 32'h0);
        apb(1'b1, `IDX_CHANNEL_CONTROL, 32'h1);
        apb(1'b1, CH6, 32'h1234);
        rdchk(CH6, 32'h1234);
        apb(1'b1, `IDX_CHANNEL_CONTROL, 32'h0);
    endtask

    task automatic t_event();
        apb(1'b1, CTL, 32'h41);
        pulses(3, 1'b1, 4);
        rdchk(CNT, 32'h3);
        chk(inputIrq, 1'b1);
        apb(1'b1, CNT, 32'h0);
        apb(1'b1, CTL, 32'h51);
        pulses(2, 1'b0, 4);
        rdchk(CNT, 32'h2);
        apb(1'b1, FLG, 32'h1);
        chk(inputIrq, 1'b0);
    endtask

    task automatic t_overflow();
        apb(1'b1, CTL, 32'h42);
        apb(1'b1, CNT, 32'hFFFF);
        pulses(1, 1'b1, 4);
        rdchk(CNT, 32'h0);
        chk(overflowIrq, 1'b1);
        apb(1'b1, FLG, 32'h2);
        chk(overflowIrq, 1'b0);
        apb(1'b1, TCR, 32'h10);
        apb(1'b1, CNT, 32'hFFFF);
        pulses(1, 1'b1, 4);
        chk(overflowIrq, 1'b1);
        rdchk(CNT, 32'h0);
        chk(overflowIrq, 1'b0);
        apb(1'b1, TCR, 32'h0);
        apb(1'b1, CTL, 32'h02);
        apb(1'b1, CNT, 32'hFFFF);
        pulses(1, 1'b1, 4);
        rdchk(CNT, 32'hFFFF);
        chk(overflowIrq, 1'b0);
    endtask

    task automatic t_gated();
        apb(1'b1, TCR, 32'h80);
        apb(1'b1, CNT, 32'h0);
        apb(1'b1, FLG, 32'h3);
        apb(1'b1, CTL, 32'h61);
        pulses(1, 1'b1, 640);
        apb(1'b0, CNT, 32'h0);
        chk(rd >= 32'h9 && rd <= 32'hB, 1'b1);
        chk(inputIrq, 1'b1);
        apb(1'b1, TCR, 32'h0);
        apb(1'b1, CNT, 32'h0);
        pulses(1, 1'b1, 200);
        rdchk(CNT, 32'h0);
    endtask

    task automatic t_port();
        apb(1'b1, `IDX_TIMER_PORT_DIRECTION, 32'h0F);
        apb(1'b1, `IDX_TIMER_PORT_PINS, 32'h05);
        chk(portOe, 8'h0F);
        chk(portOut & 8'h0F, 8'h05);
        rdchk(`IDX_TIMER_PORT_PINS, {24'h0, srcLevel[7:4], 4'h5});
    endtask

    task automatic t_modes();
        apb(1'b1, TCR, 32'h80);
        @(posedge clk);
        stopMode <= 1'b1;
        freeze(1'b1);
        stopMode <= 1'b0;
        waitMode <= 1'b1;
        freeze(1'b0);
        apb(1'b1, TCR, 32'hC0);
        freeze(1'b1);
        waitMode <= 1'b0;
        debugMode <= 1'b1;
        freeze(1'b0);
        apb(1'b1, TCR, 32'hA0);
        freeze(1'b1);
        debugMode <= 1'b0;
        apb(1'b1, TCR, 32'h0);
        freeze(1'b1);
    endtask

    task automatic t_bypass();
        apb(1'b1, TST, 32'h3);
        rdchk(TST, 32'h0);
        @(posedge clk);
        specialMode_n <= 1'b0;
        apb(1'b1, TST, 32'h3);
        rdchk(TST, 32'h3);
        apb(1'b1, TST, 32'h0);
    endtask

    task automatic endSim();
        if (errTotal == 0 && checksDone > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        {srst, specialMode_n, psel, penable, pwrite, stopMode, waitMode, debugMode} = 8'hC0;
        {paddr, pwdata, srcLevel} = {12'h000, 32'h0, 8'h60};
        errTotal = 0;
        checksDone = 0;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_event();
        t_overflow();
        t_gated();
        t_port();
        t_modes();
        t_bypass();
        endSim();
    end

    // tests take a little over a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        errTotal++;
        endSim();
    end
endmodule
